// *** logic/tqd_pkg.sv ***
// Purpose: Shared constants and types for the trigger event-delay qualifier.
// Assumes: 32-bit Avalon-MM register access with byte addresses.
// Notes: Offsets are byte addresses of aligned words.
`default_nettype none
package tqd_pkg;
  localparam int unsigned TQD_CNT_W = 29;
  localparam int unsigned TQD_ADDR_W = 4;
  localparam int unsigned TQD_DATA_W = 32;
  localparam int unsigned TQD_UP_W = 4;
  localparam logic [3:0] TQD_OFS_CTRL = 4'h0;
  localparam logic [3:0] TQD_OFS_LOAD = 4'h4;
  localparam logic [3:0] TQD_OFS_STAT = 4'h8;
  localparam logic [3:0] TQD_OFS_COUNT = 4'hc;
  localparam int unsigned TQD_CTRL_DLY = 0;
  localparam int unsigned TQD_CTRL_SHORT = 1;
  localparam int unsigned TQD_CTRL_LONG_N = 2;
  localparam int unsigned TQD_CTRL_ONE = 3;
  localparam int unsigned TQD_STAT_ARM = 0;
  localparam int unsigned TQD_STAT_ST = 1;
  localparam int unsigned TQD_STAT_TC_N = 3;
  localparam int unsigned TQD_STAT_RST = 4;
  localparam int unsigned TQD_STAT_LTO = 5;
  localparam int unsigned TQD_STAT_EARLY = 6;
  localparam int unsigned TQD_LOAD_PRE_LSB = 2;
  localparam logic [3:0] TQD_CTRL_RST = 4'h1;
  localparam logic [TQD_CNT_W-1:0] TQD_LOAD_RST = 29'h0;
  localparam logic [TQD_UP_W-1:0] TQD_UP_TC = 4'hf;
  typedef enum logic [1:0] {
    TQD_WAIT = 2'b00,
    TQD_COUNT = 2'b01,
    TQD_ARMED = 2'b10
  } tqd_state_t;
endpackage
`default_nettype wire

// *** logic/tqd_cnt_if.sv ***
// Purpose: Carries control and status between qualifier core and event counter.
// Assumes: Both ends run on the system clock.
// Notes: The core drives start, clear and settings; the counter answers.
`timescale 1ns/100ps
`default_nettype none
interface tqd_cnt_if;
  import tqd_pkg::*;
  logic start;
  logic clear;
  logic cnt_edge;
  logic [TQD_CNT_W-1:0] load;
  logic short_sel;
  logic long_en_n;
  logic one_sel;
  logic tc_n;
  logic restart;
  logic stage2;
  logic long_to;
  logic [TQD_CNT_W-1:0] count;
  modport ctrl (output start, clear, cnt_edge, load, short_sel, long_en_n, one_sel,
                input tc_n, restart, stage2, long_to, count);
  modport cnt (input start, clear, cnt_edge, load, short_sel, long_en_n, one_sel,
               output tc_n, restart, stage2, long_to, count);
endinterface
`default_nettype wire

// *** logic/tqd_evt_cnt.sv ***
// Purpose: 29-bit event delay counter with short and long sections.
// Assumes: cnt_edge is a one-cycle pulse per counter-clock rising edge.
// Notes: Terminal-count enable is active low and falls when the delay expires.
`timescale 1ns/100ps
`default_nettype none
module tqd_evt_cnt
  import tqd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  tqd_cnt_if.cnt cif
);
  logic run_q;
  logic div_q;
  logic [TQD_UP_W-1:0] up_q;
  logic [TQD_CNT_W-1:0] cnt_q;
  logic restart_q;
  logic stage2_q;
  logic tc_n_q;
  logic long_to_q;
  logic long_used;
  logic long_tc;
  logic short_done;
  logic [TQD_CNT_W-1:0] cnt_inc;

  assign long_used = !cif.short_sel && cif.long_en_n;
  assign long_tc = !long_used || long_to_q;
  assign cnt_inc = cnt_q + 29'h1;
  // Load N expires on the Nth counter edge; count-one with short select forces the first.
  assign short_done = (cnt_inc >= cif.load) || (cif.one_sel && cif.short_sel);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      restart_q <= 1'b1;
      stage2_q <= 1'b1;
      tc_n_q <= 1'b1;
    end else if (cif.clear || cif.start) begin
      run_q <= cif.start;
      cnt_q <= '0;
      restart_q <= 1'b1;
      stage2_q <= 1'b1;
      tc_n_q <= 1'b1;
    end else if (run_q && cif.cnt_edge) begin
      cnt_q <= cnt_inc;
      restart_q <= 1'b0;
      if (!restart_q) begin
        stage2_q <= 1'b0;
      end
      if (short_done && long_tc) begin
        tc_n_q <= 1'b0;
        run_q <= 1'b0;
      end
    end
  end

  // Long section steps on every second counter edge, from its preset up to 15.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 1'b0;
      up_q <= '0;
      long_to_q <= 1'b0;
    end else if (cif.clear || cif.start) begin
      div_q <= 1'b0;
      up_q <= cif.load[TQD_LOAD_PRE_LSB +: TQD_UP_W];
      long_to_q <= 1'b0;
    end else if (run_q && cif.cnt_edge && long_used) begin
      div_q <= !div_q;
      if (div_q && !long_to_q) begin
        if (up_q == TQD_UP_TC) begin
          long_to_q <= 1'b1;
        end else begin
          up_q <= up_q + 4'h1;
        end
      end
    end
  end

  assign cif.tc_n = tc_n_q;
  assign cif.restart = restart_q;
  assign cif.stage2 = stage2_q;
  assign cif.long_to = long_to_q;
  assign cif.count = cnt_q;
endmodule
`default_nettype wire

// *** logic/tqd_qualifier.sv ***
// Purpose: Event-delay trigger qualifier with Avalon-MM register access.
// Assumes: Qualifying event, trigger clock, counter clock and holdoff come from pins.
// Notes: All pin inputs pass two flip-flops before use; edges are then detected on all but holdoff, which is used as a level.
`timescale 1ns/100ps
`default_nettype none
module tqd_qualifier
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [tqd_pkg::TQD_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [tqd_pkg::TQD_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [tqd_pkg::TQD_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic qualifying_clock_event_i,
  input wire logic trigger_clock_i,
  input wire logic counter_clock_i,
  input wire logic holdoff_flag_i,
  output logic trigger_arm_enable_o,
  output logic terminal_count_enable_n_o
);
  import tqd_pkg::*;

  function automatic logic rise(input logic prev, input logic cur);
    rise = cur && !prev;
  endfunction

  function automatic logic reg_hit(input logic go, input logic [3:0] a,
                                   input logic [3:0] ofs);
    reg_hit = go && (a == ofs);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    be_merge = res;
  endfunction

  // Reset release synchroniser.
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Pin synchronisers: first stage feeds only the second stage.
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] pin_prev_q;
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      pin_meta_q <= {holdoff_flag_i, counter_clock_i, trigger_clock_i,
                     qualifying_clock_event_i};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  logic qual_rise;
  logic tclk_rise;
  logic cclk_rise;
  logic holdoff;
  assign qual_rise = rise(pin_prev_q[0], pin_sync_q[0]);
  assign tclk_rise = rise(pin_prev_q[1], pin_sync_q[1]);
  assign cclk_rise = rise(pin_prev_q[2], pin_sync_q[2]);
  assign holdoff = pin_sync_q[3];

  // Software-visible control.
  logic [3:0] ctrl_q;
  logic [TQD_CNT_W-1:0] load_q;
  logic delay_mode_select;
  logic short_count_select;
  logic long_counter_enable_n;
  logic count_one_select;
  assign delay_mode_select = ctrl_q[TQD_CTRL_DLY];
  assign short_count_select = ctrl_q[TQD_CTRL_SHORT];
  assign long_counter_enable_n = ctrl_q[TQD_CTRL_LONG_N];
  assign count_one_select = ctrl_q[TQD_CTRL_ONE];

  // Avalon slave: one wait cycle, then the access completes.
  logic wait_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_go;
  logic stat_clr;
  assign req = avs_read_i || avs_write_i;
  assign wr_go = avs_write_i && !wait_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  // Byte-enable merge is done on full words, then cut to the register width.
  logic [31:0] ctrl_wr;
  logic [31:0] load_wr;
  assign ctrl_wr = be_merge({28'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i);
  assign load_wr = be_merge({3'h0, load_q}, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= TQD_CTRL_RST;
    end else if (reg_hit(wr_go, avs_address_i, TQD_OFS_CTRL)) begin
      ctrl_q <= ctrl_wr[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_q <= TQD_LOAD_RST;
    end else if (reg_hit(wr_go, avs_address_i, TQD_OFS_LOAD)) begin
      load_q <= load_wr[TQD_CNT_W-1:0];
    end
  end

  assign stat_clr = reg_hit(wr_go, avs_address_i, TQD_OFS_STAT) && avs_byteenable_i[0]
                    && avs_writedata_i[TQD_STAT_EARLY];

  // Qualifier state.
  tqd_state_t state_q;
  logic arm_q;
  logic early_q;
  logic load_zero;
  logic direct_arm;
  tqd_cnt_if cif ();

  assign load_zero = (load_q == '0);
  // Load zero, or delay mode off, routes the count-start event straight to the output.
  assign direct_arm = load_zero || !delay_mode_select;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= TQD_WAIT;
    end else if (holdoff) begin
      state_q <= TQD_WAIT;
    end else begin
      unique case (state_q)
        TQD_WAIT: begin
          if (qual_rise) begin
            state_q <= direct_arm ? TQD_ARMED : TQD_COUNT;
          end
        end
        TQD_COUNT: begin
          if (!cif.tc_n) begin
            state_q <= TQD_ARMED;
          end
        end
        TQD_ARMED: begin
          state_q <= TQD_ARMED;
        end
        default: begin
          state_q <= TQD_WAIT;
        end
      endcase
    end
  end

  // The arm output is the qualifier's own enable flop.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      arm_q <= 1'b0;
    end else if (holdoff) begin
      arm_q <= 1'b0;
    end else if (state_q == TQD_WAIT) begin
      arm_q <= qual_rise && direct_arm;
    end else if (state_q == TQD_COUNT) begin
      arm_q <= !cif.tc_n;
    end
  end

  // Trigger clocks seen while still waiting are ignored but recorded; set wins over clear.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      early_q <= 1'b0;
    end else if (tclk_rise && (state_q == TQD_WAIT)) begin
      early_q <= 1'b1;
    end else if (stat_clr) begin
      early_q <= 1'b0;
    end
  end

  assign cif.start = (state_q == TQD_WAIT) && qual_rise && !direct_arm && !holdoff;
  assign cif.clear = holdoff;
  assign cif.cnt_edge = cclk_rise;
  assign cif.load = load_q;
  assign cif.short_sel = short_count_select;
  assign cif.long_en_n = long_counter_enable_n;
  assign cif.one_sel = count_one_select;

  tqd_evt_cnt u_cnt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .cif(cif)
  );

  // Read data is captured as the wait cycle ends.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address_i)
      TQD_OFS_CTRL: rd_mux = {28'h0, ctrl_q};
      TQD_OFS_LOAD: rd_mux = {3'h0, load_q};
      TQD_OFS_STAT: begin
        rd_mux[TQD_STAT_ARM] = arm_q;
        rd_mux[TQD_STAT_ST +: 2] = state_q;
        rd_mux[TQD_STAT_TC_N] = cif.tc_n;
        rd_mux[TQD_STAT_RST] = cif.restart;
        rd_mux[TQD_STAT_LTO] = cif.long_to;
        rd_mux[TQD_STAT_EARLY] = early_q;
        rd_mux[TQD_STAT_EARLY + 1] = cif.stage2;
      end
      TQD_OFS_COUNT: rd_mux = {3'h0, cif.count};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  logic tc_out_q;
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tc_out_q <= 1'b1;
    end else begin
      tc_out_q <= cif.tc_n;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign trigger_arm_enable_o = arm_q;
  assign terminal_count_enable_n_o = tc_out_q;
endmodule
`default_nettype wire

// *** tb/tqd_qualifier_asserts.sv ***
// Purpose: Port-level checks for the trigger event-delay qualifier.
// Assumes: One clock domain; resetn_i low clears the block.
// Notes: Age counters saturate, so every bound stays finite.
`timescale 1ns/100ps
`default_nettype none
module tqd_qualifier_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic qualifying_clock_event_i,
  input wire logic counter_clock_i,
  input wire logic holdoff_flag_i,
  input wire logic trigger_arm_enable_o,
  input wire logic terminal_count_enable_n_o
);
  logic q_prev_q;
  logic c_prev_q;
  logic [9:0] q_age_q;
  logic [9:0] c_age_q;
  logic [9:0] h_age_q;
  function automatic logic [9:0] age(input logic clr, input logic [9:0] a);
    return clr ? 10'h0 : (&a ? a : a + 10'h1);
  endfunction
  // Cycles since the last qualifying edge, counter edge and holdoff level.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_prev_q <= 1'b0;
      c_prev_q <= 1'b0;
      q_age_q <= 10'h3ff;
      c_age_q <= 10'h3ff;
      h_age_q <= 10'h3ff;
    end else begin
      q_prev_q <= qualifying_clock_event_i;
      c_prev_q <= counter_clock_i;
      q_age_q <= age(qualifying_clock_event_i && !q_prev_q, q_age_q);
      c_age_q <= age(counter_clock_i && !c_prev_q, c_age_q);
      h_age_q <= age(holdoff_flag_i, h_age_q);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  a_bus_one_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_bus_low_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("waitrequest dropped without a request");
  a_arm_needs_qual: assert property ($rose(trigger_arm_enable_o) |-> q_age_q < 10'h384)
    else $error("arm rose without a qualifying event");
  a_fall_after_hold: assert property ($fell(trigger_arm_enable_o) |-> h_age_q < 10'h10)
    else $error("arm fell without holdoff");
  a_hold_clears_arm: assert property (holdoff_flag_i [*6] |-> !trigger_arm_enable_o)
    else $error("arm still high under holdoff");
  a_hold_clears_tc: assert property (holdoff_flag_i [*6] |-> terminal_count_enable_n_o)
    else $error("terminal enable still low under holdoff");
  a_tc_after_edge: assert property ($fell(terminal_count_enable_n_o) |-> c_age_q < 10'h10)
    else $error("terminal enable fell away from a counter edge");
  a_tc_with_arm: assert property ($fell(terminal_count_enable_n_o) |-> trigger_arm_enable_o)
    else $error("terminal enable fell before arm");
endmodule
bind tqd_qualifier tqd_qualifier_asserts u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .qualifying_clock_event_i(qualifying_clock_event_i),
  .counter_clock_i(counter_clock_i),
  .holdoff_flag_i(holdoff_flag_i),
  .trigger_arm_enable_o(trigger_arm_enable_o),
  .terminal_count_enable_n_o(terminal_count_enable_n_o)
);
`default_nettype wire

// *** tb/tqd_trig_board.sv ***
// Purpose: Trigger flip-flop and holdoff of the board beside the qualifier.
// Assumes: Trigger clock comes from the bench; arm comes from the qualifier.
// Notes: Holdoff is held ten cycles, longer than the qualifier's input sync.
`timescale 1ns/100ps
`default_nettype none
module tqd_trig_board (
  input wire logic clk_i,
  input wire logic trigger_clock_i,
  input wire logic trigger_arm_enable_i,
  output logic holdoff_flag_o,
  output int trig_count_o
);
  logic tclk_q = 1'b0;
  logic hold_flag_q = 1'b0;
  int hold_q = 0;
  int trig_q = 0;
  always @(posedge clk_i) begin
    tclk_q <= trigger_clock_i;
    if (trigger_clock_i && !tclk_q && trigger_arm_enable_i && hold_q == 0) begin
      trig_q <= trig_q + 1;
      hold_flag_q <= 1'b1;
      hold_q <= 10;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
      if (hold_q == 1) begin
        hold_flag_q <= 1'b0;
      end
    end
  end
  assign holdoff_flag_o = hold_flag_q;
  assign trig_count_o = trig_q;
endmodule
`default_nettype wire

// *** tb/tqd_qualifier_tb_top.sv ***
// Purpose: Register and pin sequences for the trigger event-delay qualifier.
// Assumes: Pin pulses last six cycles high and six low.
// Notes: Arm is sampled after every counter edge to catch off-by-one delays.
`timescale 1ns/100ps
`default_nettype none
module tqd_qualifier_tb_top;
  import tqd_pkg::*;
  logic clk_i;
  logic resetn_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [TQD_ADDR_W-1:0] addr;
  logic [TQD_DATA_W-1:0] wdata;
  logic [TQD_DATA_W-1:0] rdata;
  logic [TQD_DATA_W-1:0] rd;
  logic wait_o;
  logic [2:0] pins;
  logic arm;
  logic tcn;
  logic hold;
  int trig_cnt;
  int mismatches;
  int n_checks;
  logic [31:0] st_exp;
  int ld [7] = '{0, 1, 2, 3, 5, 3, 5};
  int ne [7] = '{0, 1, 2, 3, 5, 0, 31};
  logic [31:0] ctl [7] = '{32'h1, 32'hb, 32'h3, 32'h1, 32'h3, 32'h2, 32'h5};
  logic lto [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  tqd_qualifier u_dut (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .avs_address_i(addr),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o),
    .qualifying_clock_event_i(pins[0]),
    .trigger_clock_i(pins[1]),
    .counter_clock_i(pins[2]),
    .holdoff_flag_i(hold),
    .trigger_arm_enable_o(arm),
    .terminal_count_enable_n_o(tcn)
  );
  tqd_trig_board u_board (
    .clk_i(clk_i),
    .trigger_clock_i(pins[1]),
    .trigger_arm_enable_i(arm),
    .holdoff_flag_o(hold),
    .trig_count_o(trig_cnt)
  );
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task conclude;
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    addr <= a;
    wdata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wait_o === 1'b0) break;
    end
    q = rdata;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 20) begin
      mismatches++;
      $display("FAIL bus expected answer seen timeout");
      conclude();
    end
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, exp, rd & m);
  endtask
  task pulse(input int b);
    @(posedge clk_i);
    pins[b] <= 1'b1;
    repeat (6) @(posedge clk_i);
    pins[b] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    addr = '0;
    wdata = '0;
    pins = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(TQD_OFS_CTRL, 32'hffffffff, 32'h1, "ctrl_reset");
    rd_chk(TQD_OFS_LOAD, 32'hffffffff, 32'h0, "load_reset");
    rd_chk(TQD_OFS_STAT, 32'hf, 32'h8, "status_reset");
    bus(1'b1, TQD_OFS_LOAD, 32'hffffffff, rd);
    rd_chk(TQD_OFS_LOAD, 32'hffffffff, 32'h1fffffff, "load_width");
    rd_chk(4'h2, 32'hffffffff, 32'h0, "unmapped");
    pulse(1);
    chk("early_trigger", 32'h0, 32'(trig_cnt));
    chk("early_arm", 32'h0, 32'(arm));
    rd_chk(TQD_OFS_STAT, 32'h40, 32'h40, "early_seen");
    bus(1'b1, TQD_OFS_STAT, 32'h40, rd);
    rd_chk(TQD_OFS_STAT, 32'h40, 32'h0, "early_cleared");
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, TQD_OFS_CTRL, ctl[i], rd);
      bus(1'b1, TQD_OFS_LOAD, 32'(ld[i]), rd);
      pulse(0);
      chk("arm_on_qual", 32'(ne[i] == 0), 32'(arm));
      for (int e = 1; e <= ne[i]; e++) begin
        pulse(2);
        chk("arm_on_edge", 32'(e == ne[i]), 32'(arm));
      end
      chk("terminal_n", 32'(ne[i] == 0), 32'(tcn));
      st_exp = 32'h5 | (ne[i] == 0 ? 32'h18 : 32'h0) | (lto[i] ? 32'h20 : 32'h0)
               | (ne[i] < 2 ? 32'h80 : 32'h0);
      rd_chk(TQD_OFS_COUNT, 32'h1fffffff, 32'(ne[i]), "event_count");
      rd_chk(TQD_OFS_STAT, 32'hff, st_exp, "status_armed");
      pulse(1);
      chk("trigger_count", 32'(i + 1), 32'(trig_cnt));
      chk("arm_cleared", 32'h0, 32'(arm));
      chk("terminal_cleared", 32'h1, 32'(tcn));
      rd_chk(TQD_OFS_STAT, 32'h7, 32'h0, "state_wait");
    end
    conclude();
  end
endmodule
`default_nettype wire
